// ===== ad_pkg.sv
// shared constants, register map and carrier types for the audio dac front end
package ad_pkg;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned SAMPLE_W   = 24;
   localparam int unsigned FIR_STAGES = 6;
   localparam int unsigned NS_W       = 32;
   localparam int unsigned MCNT_W     = 11;

   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_TEST   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_LEFT   = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_RIGHT  = 8'h10;

   localparam int unsigned CTRL_W        = 6;
   localparam int unsigned CTRL_FMT_LSB  = 0;
   localparam int unsigned CTRL_MUTE_BIT = 2;
   localparam int unsigned CTRL_DEEMPHASIS_ENABLE_BIT = 3;
   localparam int unsigned CTRL_MODE_LSB = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam int unsigned TEST_W        = 2;
   localparam int unsigned TEST_SIL_BIT  = 0;
   localparam int unsigned TEST_HOLD_BIT = 1;
   localparam logic [TEST_W-1:0] TEST_RESET = 2'h0;

   localparam int unsigned STAT_RATIO_LSB = 0;
   localparam int unsigned STAT_VALID_BIT = 3;
   localparam int unsigned STAT_SIL_BIT   = 4;
   localparam int unsigned STAT_BAD_BIT   = 5;
   localparam int unsigned STAT_POR_BIT   = 6;

   localparam logic [1:0] FMT_I2S   = 2'h0;
   localparam logic [1:0] FMT_LSB16 = 2'h1;
   localparam logic [1:0] FMT_LSB20 = 2'h2;
   localparam logic [1:0] FMT_LSB24 = 2'h3;

   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_LOW    = 2'h1;
   localparam logic [1:0] MODE_SLEEP  = 2'h2;

   localparam logic [2:0] RATIO_NONE = 3'h7;
   localparam logic [2:0] RATIO_FIRST_LOW_BAD = 3'h4;
   localparam int RATIO_TAB [6] = '{768, 512, 384, 256, 192, 128};
   localparam int OS_NORMAL = 64;
   localparam int OS_LOW    = 128;

   localparam int unsigned SYS_CLK_MHZ = 40;
   localparam int unsigned POR_TIME_NS = 1000;
   localparam int unsigned POR_CYCLES  = (POR_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam logic [8:0] GAIN_MAX = 9'h100;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } ad_axi_req_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } ad_axi_rsp_s;

   function automatic logic [2:0] ad_ratio_code(input logic [MCNT_W-1:0] n);
      ad_ratio_code = RATIO_NONE;
      for (int i = 0; i < 6; i++) begin
         if ((int'(n) + 1 >= RATIO_TAB[i]) && (int'(n) <= RATIO_TAB[i] + 1)) begin
            ad_ratio_code = 3'(i);
         end
      end
   endfunction
endpackage

// ===== ad_sync.sv
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module ad_sync
   import ad_pkg::*;
#(
   parameter int unsigned W = 4
) (
   input  wire logic         sys_clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ad_sync_s;

   ad_sync_s q;
   ad_sync_s d;

   always_comb begin
      d    = q;
      d.s1 = pin_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < int'(W); i++) begin
         // a change counts only once second and third stage agree
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level_o = q.lvl;
endmodule

// ===== ad_shaper.sv
// fifth-order one-bit noise shaper for one channel
`timescale 1ns/1ps
module ad_shaper
   import ad_pkg::*;
(
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       step_i,
   input  wire logic                       sleep_i,
   input  wire logic signed [SAMPLE_W-1:0] sample_i,
   output logic                            bit_o
);
   localparam logic signed [NS_W-1:0] FULL_SCALE = 32'sh0080_0000;
   localparam logic signed [NS_W-1:0] LIMIT      = 32'sh1000_0000;

   typedef struct packed {
      logic [4:0][NS_W-1:0] integ;
      logic                 bitv;
   } ad_shaper_s;

   ad_shaper_s q;
   ad_shaper_s d;

   // clamping keeps an overloaded loop from wrapping round
   function automatic logic signed [NS_W-1:0] clamp(input logic signed [NS_W-1:0] v);
      if (v > LIMIT) begin
         clamp = LIMIT;
      end else if (v < -LIMIT) begin
         clamp = -LIMIT;
      end else begin
         clamp = v;
      end
   endfunction

   always_comb begin
      logic signed [NS_W-1:0] fb;
      logic signed [NS_W-1:0] acc;
      fb  = '0;
      acc = '0;
      d   = q;
      fb  = q.bitv ? FULL_SCALE : -FULL_SCALE;
      if (sleep_i) begin
         d = '0;
      end else if (step_i) begin
         acc        = $signed(q.integ[0]) + NS_W'(sample_i) - fb;
         d.integ[0] = clamp(acc);
         for (int k = 1; k < 5; k++) begin
            acc        = $signed(q.integ[k]) + ($signed(q.integ[k-1]) >>> 2) - (fb >>> (k + 1));
            d.integ[k] = clamp(acc);
         end
         d.bitv = ($signed(d.integ[4]) >= 0);
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bit_o = q.bitv;
endmodule

// ===== ad_top.sv
// audio dac digital front end: serial receiver, ratio detect, fir, mute, shaper
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ad_top
   import ad_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire ad_axi_req_s axi_req_i,
   output ad_axi_rsp_s      axi_rsp_o,
   input  wire logic        bit_clock_in_i,
   input  wire logic        word_select_i,
   input  wire logic        serial_data_i,
   input  wire logic        master_clock_in_i,
   output logic [1:0]       bitstream_o,
   output logic             silence_switch_o,
   output logic             power_down_o
);
   typedef logic signed [SAMPLE_W-1:0] smp_t;

   typedef struct packed {
      ad_axi_rsp_s                 rsp;
      logic                        aw_have;
      logic [ADDR_W-1:0]           aw_addr;
      logic                        w_have;
      logic [DATA_W-1:0]           w_data;
      logic [3:0]                  w_strb;
      logic [CTRL_W-1:0]           ctrl;
      logic [TEST_W-1:0]           test;
      logic [5:0]                  por_cnt;
      logic                        por_busy;
      logic                        bck_prev;
      logic                        ws_bck;
      logic [SAMPLE_W-1:0]         sr;
      logic [SAMPLE_W-1:0]         iw;
      logic [4:0]                  cnt;
      logic [1:0][SAMPLE_W-1:0]    word;
      logic                        frame;
      logic                        mclk_prev;
      logic                        ws_sys_prev;
      logic [MCNT_W-1:0]           mcnt;
      logic [2:0]                  ratio;
      logic [3:0]                  div_cnt;
      logic                        os_en;
      logic [1:0][SAMPLE_W-1:0]    de;
      logic [8:0]                  gain;
      logic [1:0][SAMPLE_W-1:0]    hold;
      logic [1:0][FIR_STAGES-1:0][SAMPLE_W-1:0] fir;
      logic                        silence;
      logic                        sleep;
   } ad_top_s;

   ad_top_s    q;
   ad_top_s    d;
   logic [3:0] sy;
   logic       s_bck;
   logic       s_ws;
   logic       s_data;
   logic       s_mclk;

   ad_sync #(
      .W (4)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     ({master_clock_in_i, serial_data_i, word_select_i, bit_clock_in_i}),
      .level_o   (sy)
   );

   assign s_bck  = sy[0];
   assign s_ws   = sy[1];
   assign s_data = sy[2];
   assign s_mclk = sy[3];

   function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0]        strb);
      wmerge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            wmerge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // i2s word: msb came one bck after the ws change, lsb arrives with the next change
   function automatic logic [SAMPLE_W-1:0] i2s_word(input logic [SAMPLE_W-1:0] iw,
                                                    input logic                lsb,
                                                    input logic [4:0]          cnt);
      logic [SAMPLE_W-1:0] full;
      full = {iw[SAMPLE_W-2:0], lsb};
      if (cnt < 5'd24) begin
         i2s_word = full << (5'd23 - cnt);
      end else begin
         i2s_word = iw;
      end
   endfunction

   // lsb-justified word: the last n bits before the ws change, left aligned
   function automatic logic [SAMPLE_W-1:0] lsb_word(input logic [SAMPLE_W-1:0] sr,
                                                    input logic [1:0]          fmt);
      case (fmt)
         FMT_LSB16: lsb_word = sr << 8;
         FMT_LSB20: lsb_word = sr << 4;
         default:   lsb_word = sr;
      endcase
   endfunction

   // 3/4 current plus 1/4 last output: a one-pole treble cut at the sample rate
   function automatic smp_t deemphasis_enable_f(input smp_t x, input smp_t prev, input logic on);
      logic signed [SAMPLE_W+1:0] acc;
      acc = ($signed({x, 1'b0}) + (SAMPLE_W+2)'(x) + (SAMPLE_W+2)'(prev)) >>> 2;
      deemphasis_enable_f = on ? SAMPLE_W'(acc) : x;
   endfunction

   function automatic smp_t apply_gain(input smp_t x, input logic [8:0] g);
      logic signed [SAMPLE_W+9:0] p;
      p = (SAMPLE_W+10)'(x) * $signed({1'b0, g});
      apply_gain = SAMPLE_W'(p >>> 8);
   endfunction

   // master clock edges per oversampling step; zero marks an unusable ratio
   function automatic logic [3:0] os_div(input logic [2:0] code, input logic low);
      os_div = 4'h0;
      if (code < 3'd6) begin
         if (!low) begin
            os_div = 4'(RATIO_TAB[code] / OS_NORMAL);
         end else if (code < RATIO_FIRST_LOW_BAD) begin
            os_div = 4'(RATIO_TAB[code] / OS_LOW);
         end
      end
   endfunction

   always_comb begin
      logic [DATA_W-1:0]   wv;
      logic [DATA_W-1:0]   rv;
      logic [1:0]          rsp;
      logic [SAMPLE_W-1:0] nw;
      logic [1:0]          fmt;
      logic                mute;
      logic                low;
      logic [3:0]          div;
      smp_t                src;
      wv   = '0;
      rv   = '0;
      rsp  = RESP_OKAY;
      nw   = '0;
      src  = '0;
      d    = q;
      fmt  = q.ctrl[CTRL_FMT_LSB +: 2];
      mute = q.ctrl[CTRL_MUTE_BIT];
      low  = (q.ctrl[CTRL_MODE_LSB +: 2] == MODE_LOW);
      div  = os_div(q.ratio, low);

      // internal reset stretch keeps test control cleared
      if (q.por_cnt != 6'h00) begin
         d.por_cnt = q.por_cnt - 6'h01;
      end
      d.por_busy = (d.por_cnt != 6'h00);
      if (d.por_busy) begin
         d.test = TEST_RESET;
      end

      // register write path: address and data taken in either order
      if (axi_req_i.awvalid && q.rsp.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && q.rsp.wready) begin
         d.w_have = 1'b1;
         d.w_data = axi_req_i.wdata;
         d.w_strb = axi_req_i.wstrb;
      end
      if (q.rsp.bvalid && axi_req_i.bready) begin
         d.rsp.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
         d.aw_have    = 1'b0;
         d.w_have     = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp  = RESP_OKAY;
         case (q.aw_addr)
            REG_CTRL: begin
               wv     = wmerge(DATA_W'(q.ctrl), q.w_data, q.w_strb);
               d.ctrl = wv[CTRL_W-1:0];
            end
            REG_TEST: begin
               wv = wmerge(DATA_W'(q.test), q.w_data, q.w_strb);
               if (!q.por_busy) begin
                  d.test = wv[TEST_W-1:0];
               end
            end
            REG_STATUS, REG_LEFT, REG_RIGHT: begin
            end
            default: begin
               d.rsp.bresp = RESP_SLVERR;
            end
         endcase
      end
      d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
      d.rsp.wready  = !d.w_have && !d.rsp.bvalid;

      // register read path
      if (q.rsp.rvalid && axi_req_i.rready) begin
         d.rsp.rvalid = 1'b0;
      end
      if (axi_req_i.arvalid && q.rsp.arready) begin
         case (axi_req_i.araddr)
            REG_CTRL: rv = DATA_W'(q.ctrl);
            REG_TEST: rv = DATA_W'(q.test);
            REG_STATUS: begin
               rv[STAT_RATIO_LSB +: 3] = q.ratio;
               rv[STAT_VALID_BIT]      = (q.ratio != RATIO_NONE);
               rv[STAT_SIL_BIT]        = q.silence;
               rv[STAT_BAD_BIT]        = (div == 4'h0);
               rv[STAT_POR_BIT]        = q.por_busy;
            end
            REG_LEFT:  rv = DATA_W'(q.word[0]);
            REG_RIGHT: rv = DATA_W'(q.word[1]);
            default:   rsp = RESP_SLVERR;
         endcase
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata  = rv;
         d.rsp.rresp  = rsp;
      end
      d.rsp.arready = !d.rsp.rvalid;

      // serial receiver, slave to the source's bit clock and word select
      d.frame    = 1'b0;
      d.bck_prev = s_bck;
      if (s_bck && !q.bck_prev) begin
         d.sr = {q.sr[SAMPLE_W-2:0], s_data};
         if (s_ws != q.ws_bck) begin
            if (fmt == FMT_I2S) begin
               nw = i2s_word(q.iw, s_data, q.cnt);
            end else begin
               nw = lsb_word(q.sr, fmt);
            end
            d.word[q.ws_bck] = nw;
            d.frame          = q.ws_bck;
            d.cnt            = 5'h00;
         end else begin
            if (q.cnt < 5'd24) begin
               d.iw = {q.iw[SAMPLE_W-2:0], s_data};
            end
            if (q.cnt != 5'h1f) begin
               d.cnt = q.cnt + 5'h01;
            end
         end
         d.ws_bck = s_ws;
      end

      // ratio detect: master clock edges per word select period
      d.mclk_prev   = s_mclk;
      d.ws_sys_prev = s_ws;
      d.os_en       = 1'b0;
      if (s_ws && !q.ws_sys_prev) begin
         d.ratio = ad_ratio_code(q.mcnt);
         d.mcnt  = '0;
      end else if (s_mclk && !q.mclk_prev && (q.mcnt != '1)) begin
         d.mcnt = q.mcnt + MCNT_W'(1);
      end
      // an unsupported ratio stops the oversampling clock entirely
      if (div == 4'h0) begin
         d.div_cnt = 4'h0;
      end else if (s_mclk && !q.mclk_prev) begin
         if (q.div_cnt + 4'h1 >= div) begin
            d.div_cnt = 4'h0;
            d.os_en   = 1'b1;
         end else begin
            d.div_cnt = q.div_cnt + 4'h1;
         end
      end

      // per-frame de-emphasis and soft mute ramp
      if (q.frame) begin
         for (int c = 0; c < 2; c++) begin
            d.de[c]   = deemphasis_enable_f(smp_t'(q.word[c]), smp_t'(q.de[c]),
                               q.ctrl[CTRL_DEEMPHASIS_ENABLE_BIT]);
            d.hold[c] = apply_gain(smp_t'(d.de[c]), q.gain);
         end
         if (mute) begin
            if (q.gain != 9'h000) begin
               d.gain = q.gain - 9'h001;
            end
         end else if (q.gain != GAIN_MAX) begin
            d.gain = q.gain + 9'h001;
         end
      end
      d.silence = (mute && (q.gain == 9'h000)) || q.test[TEST_SIL_BIT];

      // fir smoothing cascade runs on every oversampling step
      if (q.os_en) begin
         for (int c = 0; c < 2; c++) begin
            for (int s = 0; s < int'(FIR_STAGES); s++) begin
               src = (s == 0) ? smp_t'(q.hold[c]) : smp_t'(q.fir[c][s-1]);
               d.fir[c][s] = SAMPLE_W'(((SAMPLE_W+1)'(src) +
                             (SAMPLE_W+1)'(smp_t'(q.fir[c][s]))) >>> 1);
            end
         end
      end

      d.sleep = (q.ctrl[CTRL_MODE_LSB +: 2] == MODE_SLEEP) ||
                (q.ctrl[CTRL_MODE_LSB +: 2] == 2'h3);
      if (d.sleep) begin
         d.fir  = '0;
         d.hold = '0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q          <= '0;
         q.ctrl     <= CTRL_RESET;
         q.test     <= TEST_RESET;
         q.por_cnt  <= 6'(POR_CYCLES);
         q.por_busy <= 1'b1;
         q.ratio    <= RATIO_NONE;
         q.gain     <= GAIN_MAX;
      end else begin
         q <= d;
      end
   end

   // shapers step with the fir but can be frozen for test
   for (genvar c = 0; c < 2; c++) begin : g_ch
      ad_shaper u_shaper (
         .sys_clk_i (sys_clk_i),
         .reset_n_i (reset_n_i),
         .step_i    (q.os_en && !q.test[TEST_HOLD_BIT]),
         .sleep_i   (q.sleep),
         .sample_i  (smp_t'(q.fir[c][FIR_STAGES-1])),
         .bit_o     (bitstream_o[c])
      );
   end

   assign axi_rsp_o        = q.rsp;
   assign silence_switch_o = q.silence;
   assign power_down_o     = q.sleep;
endmodule

// ===== ad_chk.sv
// port checker for the audio dac front end, bound into ad_top
`timescale 1ns/1ps
module ad_chk
   import ad_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire ad_axi_req_s axi_req_i,
   input wire ad_axi_rsp_s axi_rsp_o,
   input wire logic        bit_clock_in_i,
   input wire logic        word_select_i,
   input wire logic        serial_data_i,
   input wire logic        master_clock_in_i,
   input wire logic [1:0]  bitstream_o,
   input wire logic        silence_switch_o,
   input wire logic        power_down_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [5:0] por_q;
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         por_q <= 6'h00;
      end else if (por_q < 6'(POR_CYCLES)) begin
         por_q <= por_q + 6'h01;
      end
   end
   property p_por_quiet; por_q < 6'(POR_CYCLES) |-> !silence_switch_o; endproperty
   property p_sleep_quiet; power_down_o [*4] |-> bitstream_o == 2'h0; endproperty
   // steps come at most every two master edges, so a bit never flips twice in a row
   property p_bits_slow;
      $changed(bitstream_o) && !power_down_o |=> (!$changed(bitstream_o) || power_down_o) [*4];
   endproperty
   property p_b_after;
      axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready
         |-> ##[1:3] axi_rsp_o.bvalid;
   endproperty
   property p_b_hold;
      axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
   endproperty
   property p_r_hold;
      axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
   endproperty
   property p_r_after; axi_req_i.arvalid && axi_rsp_o.arready |-> ##[1:2] axi_rsp_o.rvalid;
   endproperty
   property p_ar_busy; axi_rsp_o.rvalid |-> !axi_rsp_o.arready; endproperty
   a_por_quiet: assert property (p_por_quiet)
      else $error("silence switch closed inside reset stretch");
   a_sleep_quiet: assert property (p_sleep_quiet)
      else $error("bitstream active in sleep");
   a_bits_slow: assert property (p_bits_slow)
      else $error("bitstream changed faster than oversampling steps");
   a_b_after: assert property (p_b_after)
      else $error("write response late");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped before rready");
   a_r_after: assert property (p_r_after)
      else $error("read response late");
   a_ar_busy: assert property (p_ar_busy)
      else $error("arready high while read pending");
   c_slverr: cover property (axi_rsp_o.rvalid && axi_rsp_o.rresp == RESP_SLVERR);
   c_sleep: cover property (power_down_o);
   c_bits: cover property ($changed(bitstream_o));
endmodule

bind ad_top ad_chk chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o), .bit_clock_in_i(bit_clock_in_i), .word_select_i(word_select_i),
   .serial_data_i(serial_data_i), .master_clock_in_i(master_clock_in_i),
   .bitstream_o(bitstream_o), .silence_switch_o(silence_switch_o), .power_down_o(power_down_o));

// ===== ad_src.sv
// serial audio source: free master clock, frame-gated bit clock, word select, data
`timescale 1ns/1ps
module ad_src
   import ad_pkg::*;
(
   output logic mclk_o,
   output logic bck_o,
   output logic ws_o,
   output logic sd_o
);
   logic [31:0] slot;
   logic        prev;
   initial begin
      mclk_o = 1'b0;
      bck_o = 1'b1;
      ws_o = 1'b1;
      sd_o = 1'b0;
      prev = 1'b0;
   end
   // master runs free, also through reset; slowed so the sampler sees each phase
   initial forever #80 mclk_o = ~mclk_o;
   function automatic logic [31:0] mk(input logic [1:0] f, input logic [23:0] s, input logic p);
      int n;
      n = (f == FMT_LSB16) ? 16 : (f == FMT_LSB20) ? 20 : 24;
      if (f == FMT_I2S) mk = {p, s, 7'h55};
      else mk = (32'haaaaaaaa << n) | (32'(s) >> (24 - n));
   endfunction
   // bit clock derived from master so the frame spans exactly ratio master periods
   task automatic send(input int nf, input logic [1:0] f, input int ratio,
                       input logic [23:0] l, input logic [23:0] r);
      int h;
      h = ratio / 64;
      repeat (nf) for (int c = 0; c < 2; c++) begin
         slot = mk(f, (c == 1) ? r : l, prev);
         for (int k = 31; k >= 0; k--) begin
            repeat (h) @(mclk_o);
            bck_o = 1'b0;
            ws_o = (c == 1);
            sd_o = slot[k];
            repeat (h) @(mclk_o);
            bck_o = 1'b1;
         end
         prev = (c == 1) ? r[0] : l[0];
      end
      repeat (h) @(mclk_o);
      sd_o = ~sd_o;
   endtask
endmodule

// ===== ad_top_tb.sv
// self-checking bench for the audio dac front end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ad_top_tb
   import ad_pkg::*;
;
   localparam logic [ADDR_W-1:0] UNMAPPED = 8'h14;
   logic        sys_clk_i;
   logic        reset_n_i;
   ad_axi_req_s q;
   ad_axi_rsp_s s;
   logic        bit_clock_in;
   logic        ws;
   logic        sd;
   logic        mclk;
   logic        sil;
   logic        pd;
   logic [1:0]  bits;
   logic [1:0]  rr;
   logic [31:0] seed;
   // alternate calls answer late so the response-hold checks see a stalled handshake
   logic        lag;
   logic [31:0] d;
   logic [23:0] l;
   logic [23:0] r;
   int          n_fail;
   int          samples_checked;
   ad_top dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .axi_req_i(q), .axi_rsp_o(s),
      .bit_clock_in_i(bit_clock_in), .word_select_i(ws), .serial_data_i(sd), .master_clock_in_i(mclk),
      .bitstream_o(bits), .silence_switch_o(sil), .power_down_o(pd));
   ad_src src_u (.mclk_o(mclk), .bck_o(bit_clock_in), .ws_o(ws), .sd_o(sd));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [23:0] exp_w(input logic [1:0] f, input logic [23:0] v);
      case (f)
         FMT_LSB16: return {v[23:8], 8'h00};
         FMT_LSB20: return {v[23:4], 4'h0};
         default: return v;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] b);
      @(posedge sys_clk_i);
      lag = ~lag;
      q.awvalid <= 1'b1;
      q.awaddr <= a;
      q.wvalid <= 1'b1;
      q.wdata <= v;
      q.wstrb <= 4'hf;
      q.bready <= !lag;
      forever begin
         @(posedge sys_clk_i);
         if (q.awvalid && s.awready) q.awvalid <= 1'b0;
         if (q.wvalid && s.wready) q.wvalid <= 1'b0;
         if (s.bvalid && q.bready) begin
            b = s.bresp;
            q.bready <= 1'b0;
            break;
         end
         if (s.bvalid) q.bready <= 1'b1;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
      @(posedge sys_clk_i);
      lag = ~lag;
      q.arvalid <= 1'b1;
      q.araddr <= a;
      q.rready <= !lag;
      forever begin
         @(posedge sys_clk_i);
         if (q.arvalid && s.arready) q.arvalid <= 1'b0;
         if (s.rvalid && q.rready) begin
            v = s.rdata;
            b = s.rresp;
            q.rready <= 1'b0;
            break;
         end
         if (s.rvalid) q.rready <= 1'b1;
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2500000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h19f7faae;
      lag = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      q = '0;
      reset_n_i = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      // test write lands inside the stretch and must be dropped
      wr(REG_TEST, 32'h1, rr);
      rd(REG_TEST, d, rr);
      `CHK("test_por", 32'h0, d)
      rd(REG_STATUS, d, rr);
      `CHK("por_busy", 1'b1, d[STAT_POR_BIT])
      repeat (POR_CYCLES) @(posedge sys_clk_i);
      rd(REG_STATUS, d, rr);
      `CHK("por_done", 1'b0, d[STAT_POR_BIT])
      rd(REG_CTRL, d, rr);
      `CHK("ctrl_rst", 32'h0, d)
      rd(UNMAPPED, d, rr);
      `CHK("unmapped_r", RESP_SLVERR, rr)
      wr(UNMAPPED, 32'h1, rr);
      `CHK("unmapped_w", RESP_SLVERR, rr)
      wr(REG_TEST, 32'h1, rr);
      repeat (3) @(posedge sys_clk_i);
      `CHK("sil_test", 1'b1, sil)
      wr(REG_TEST, 32'h0, rr);
      // no ratio yet, so no shaper steps can race the sleep clear
      for (int m = 0; m < 4; m++) begin
         wr(REG_CTRL, 32'(m) << CTRL_MODE_LSB, rr);
         repeat (6) @(posedge sys_clk_i);
         `CHK("sleep", m >= 2, pd)
         `CHK("sleep_bits", 2'h0, bits)
      end
      for (int f = 0; f < 4; f++) begin
         d = xs();
         l = d[23:0];
         d = xs();
         r = d[23:0];
         wr(REG_CTRL, 32'(f), rr);
         src_u.send(2, f[1:0], 128, l, r);
         repeat (20) @(posedge sys_clk_i);
         rd(REG_LEFT, d, rr);
         `CHK("left", exp_w(f[1:0], l), d[23:0])
         rd(REG_RIGHT, d, rr);
         `CHK("right", exp_w(f[1:0], r), d[23:0])
      end
      wr(REG_CTRL, 32'hc, rr);
      repeat (4) @(posedge sys_clk_i);
      `CHK("sil_mute", 1'b0, sil)
      for (int i = 0; i < 6; i++) begin
         src_u.send(2, FMT_I2S, RATIO_TAB[i], l, r);
         repeat (10) @(posedge sys_clk_i);
         rd(REG_STATUS, d, rr);
         `CHK("ratio", 3'(i), d[2:0])
         `CHK("ratio_ok", 1'b1, d[STAT_VALID_BIT])
         `CHK("ratio_bad", 1'b0, d[STAT_BAD_BIT])
      end
      wr(REG_CTRL, 32'(MODE_LOW) << CTRL_MODE_LSB, rr);
      for (int i = 3; i < 6; i++) begin
         src_u.send(2, FMT_I2S, RATIO_TAB[i], l, r);
         repeat (10) @(posedge sys_clk_i);
         rd(REG_STATUS, d, rr);
         `CHK("low_bad", i >= 4, d[STAT_BAD_BIT])
      end
      tally_and_finish();
   end
endmodule
